// file: verilog/usb_irq_token_pkg.sv
package usb_irq_token_pkg;

  // Register byte offsets
  localparam logic [7:0] OTG_STATUS_OFS      = 8'h00;
  localparam logic [7:0] OTG_IRQ_EN_OFS      = 8'h04;
  localparam logic [7:0] USB_STATUS_OFS      = 8'h08;
  localparam logic [7:0] USB_IRQ_EN_OFS      = 8'h0C;
  localparam logic [7:0] FRAME_HIGH_OFS      = 8'h10;
  localparam logic [7:0] HOST_TOKEN_OFS      = 8'h14;
  localparam logic [7:0] CONTROL_OFS         = 8'h18;

  // OTG enable and status field positions
  localparam int ID_CHANGE_BIT      = 7;
  localparam int ONE_MS_TIMER_BIT   = 6;
  localparam int LINE_STATE_BIT     = 5;
  localparam int BUS_ACTIVITY_BIT   = 4;
  localparam int SESSION_VALID_BIT  = 3;
  localparam int B_SESSION_END_BIT  = 2;
  localparam int A_VBUS_VALID_BIT   = 0;
  localparam logic [7:0] OTG_IMPL_MASK = 8'hFD;

  // USB enable and status field positions
  localparam int STALL_BIT          = 7;
  localparam int ATTACH_BIT         = 6;
  localparam int RESUME_BIT         = 5;
  localparam int BUS_IDLE_BIT       = 4;
  localparam int TOKEN_DONE_BIT     = 3;
  localparam int FRAME_START_BIT    = 2;
  localparam int ERROR_BIT          = 1;
  localparam int RESET_DETACH_BIT   = 0;
  localparam logic [7:0] USB_IMPL_MASK = 8'hFF;

  // Frame number high field
  localparam int FRAME_UPPER_LSB    = 8;
  localparam int FRAME_UPPER_WIDTH  = 3;

  // Token register fields
  localparam int TOKEN_PID_LSB      = 4;
  localparam int TOKEN_EP_LSB       = 0;
  localparam logic [3:0] PID_OUT    = 4'h1;
  localparam logic [3:0] PID_IN     = 4'h9;
  localparam logic [3:0] PID_SETUP  = 4'hD;

  // Control register fields
  localparam int HOST_MODE_BIT      = 0;
  localparam int TOKEN_BUSY_BIT     = 1;

  // Reset values
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] TOKEN_RESET  = 8'h00;
  localparam logic [2:0] FRAME_RESET  = 3'h0;

  typedef enum logic [0:0] {
    TOKEN_IDLE = 1'b0,
    TOKEN_BUSY = 1'b1
  } token_state_type;

endpackage

// file: verilog/sticky_flag_bank.sv
`timescale 1ns/1ps
`default_nettype none

// Sticky event flags, cleared by writing one, gated by an enable mask
module sticky_flag_bank
  import usb_irq_token_pkg::*;
#(
  parameter int          WIDTH     = 8,
  parameter logic [7:0]  IMPL_MASK = 8'hFF
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Event side
  input  wire logic [WIDTH-1:0] set_pulse,
  // Software clear
  input  wire logic             clear_strobe,
  input  wire logic [WIDTH-1:0] clear_data,
  // Gating and result
  input  wire logic [WIDTH-1:0] enable,
  output logic      [WIDTH-1:0] flags,
  output logic                  irq
);

  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;
  logic [WIDTH-1:0] clear_mask;

  always_comb begin
    clear_mask = clear_strobe ? clear_data : '0;
    // Set wins over a clear in the same cycle
    flags_next = ((flags_reg & ~clear_mask) | set_pulse)
                 & IMPL_MASK[WIDTH-1:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;
  // Enable only gates, never touches the flag
  assign irq   = |(flags_reg & enable);

endmodule // sticky_flag_bank

`default_nettype wire

// file: verilog/usb_irq_token_regs.sv
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - OTG enable bits 7 ID, 6 timer
// - OTG enable bits 5 line state, 4 activity
// - OTG enable bits 3, 2, 0 session/VBUS
// - Unimplemented enable bits read zero
// - USB enable bits 7 stall, 6 attach
// - USB enable bits 5 resume, 4 idle
// - Bit 3 token done, bit 2 SOF
// - Bit 1 gates error interrupts
// - Bit 0 reset in device, detach host
// - Upper frame bits reload on SOF
// - Token type field bits 7 to 4
module usb_irq_token_regs
  import usb_irq_token_pkg::*;
#(
  parameter int ADDR_WIDTH  = 8,
  parameter int FRAME_WIDTH = 11
) (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [ADDR_WIDTH-1:0]  paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // OTG events, one-cycle pulses
  input  wire logic                   id_change_event,
  input  wire logic                   one_ms_timer_event,
  input  wire logic                   line_state_event,
  input  wire logic                   bus_activity_event,
  input  wire logic                   session_valid_event,
  input  wire logic                   b_session_end_event,
  input  wire logic                   a_vbus_valid_event,
  // USB events, one-cycle pulses
  input  wire logic                   stall_event,
  input  wire logic                   attach_event,
  input  wire logic                   resume_event,
  input  wire logic                   bus_idle_event,
  input  wire logic                   error_event,
  input  wire logic                   bus_reset_event,
  input  wire logic                   peer_detach_event,
  // Frame start from the serial engine
  input  wire logic                   sof_received,
  input  wire logic [FRAME_WIDTH-1:0] frame_number,
  // Host transaction request and completion
  output logic                        token_start,
  output logic      [3:0]             token_pid,
  output logic      [3:0]             token_endpoint,
  input  wire logic                   transaction_done,
  // Mode and interrupt
  output logic                        host_mode,
  output logic                        combined_usb_irq
);

  logic                   setup_phase;
  logic                   access_phase;
  logic                   wr_access;
  logic                   addr_known;
  logic [7:0]             otg_irq_en_reg;
  logic [7:0]             usb_irq_en_reg;
  logic [2:0]             frame_upper_reg;
  logic [7:0]             host_token_reg;
  logic                   host_mode_reg;
  token_state_type        token_state_reg;
  logic                   token_start_reg;
  logic [31:0]            prdata_reg;
  logic [7:0]             otg_set;
  logic [7:0]             usb_set;
  logic [7:0]             otg_flags;
  logic [7:0]             usb_flags;
  logic                   otg_irq;
  logic                   usb_irq;
  logic                   otg_clear;
  logic                   usb_clear;
  logic                   token_write;
  logic                   token_done_flag;
  logic                   frame_start_flag;
  logic                   bus_reset_flag;
  logic                   peer_detach_flag;

  // Offset match on the word address
  function automatic logic hit(input logic [ADDR_WIDTH-1:0] a,
                               input logic [7:0] ofs);
    hit = (a[ADDR_WIDTH-1:2] == ADDR_WIDTH'(ofs) >> 2) &&
          (a[1:0] == 2'b00);
  endfunction

  function automatic logic [31:0] word8(input logic [7:0] v);
    word8 = {24'h000000, v};
  endfunction

  // APB phase decode
  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;
  assign wr_access    = access_phase && pwrite;

  always_comb begin
    addr_known = hit(paddr, OTG_STATUS_OFS) ||
                 hit(paddr, OTG_IRQ_EN_OFS) ||
                 hit(paddr, USB_STATUS_OFS) ||
                 hit(paddr, USB_IRQ_EN_OFS) ||
                 hit(paddr, FRAME_HIGH_OFS) ||
                 hit(paddr, HOST_TOKEN_OFS) ||
                 hit(paddr, CONTROL_OFS);
  end

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = access_phase && !addr_known;

  // OTG enable register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      otg_irq_en_reg <= ENABLE_RESET;
    end else if (wr_access && hit(paddr, OTG_IRQ_EN_OFS)) begin
      otg_irq_en_reg <= pwdata[7:0] & OTG_IMPL_MASK;
    end
  end

  // USB enable register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_irq_en_reg <= ENABLE_RESET;
    end else if (wr_access && hit(paddr, USB_IRQ_EN_OFS)) begin
      usb_irq_en_reg <= pwdata[7:0] & USB_IMPL_MASK;
    end
  end

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_mode_reg <= 1'b0;
    end else if (wr_access && hit(paddr, CONTROL_OFS)) begin
      host_mode_reg <= pwdata[HOST_MODE_BIT];
    end
  end

  // Upper frame bits follow each SOF
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_upper_reg <= FRAME_RESET;
    end else if (sof_received) begin
      frame_upper_reg <=
        frame_number[FRAME_UPPER_LSB +: FRAME_UPPER_WIDTH];
    end
  end

  // Token register and transaction launch
  assign token_write = wr_access && hit(paddr, HOST_TOKEN_OFS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_token_reg <= TOKEN_RESET;
    end else if (token_write && token_state_reg == TOKEN_IDLE) begin
      host_token_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      token_state_reg <= TOKEN_IDLE;
      token_start_reg <= 1'b0;
    end else begin
      token_start_reg <= 1'b0;
      case (token_state_reg)
        TOKEN_IDLE: begin
          if (token_write && host_mode_reg) begin
            token_state_reg <= TOKEN_BUSY;
            token_start_reg <= 1'b1;
          end
        end
        TOKEN_BUSY: begin
          if (transaction_done) begin
            token_state_reg <= TOKEN_IDLE;
          end
        end
        default: begin
          token_state_reg <= TOKEN_IDLE;
        end
      endcase
    end
  end

  assign token_start    = token_start_reg;
  assign token_pid      = host_token_reg[TOKEN_PID_LSB +: 4];
  assign token_endpoint = host_token_reg[TOKEN_EP_LSB +: 4];

  // Event flags
  assign token_done_flag  = (token_state_reg == TOKEN_BUSY) &&
                            transaction_done;
  assign frame_start_flag = sof_received;
  assign bus_reset_flag   = !host_mode_reg && bus_reset_event;
  assign peer_detach_flag = host_mode_reg && peer_detach_event;

  always_comb begin
    otg_set                    = 8'h00;
    otg_set[ID_CHANGE_BIT]     = id_change_event;
    otg_set[ONE_MS_TIMER_BIT]  = one_ms_timer_event;
    otg_set[LINE_STATE_BIT]    = line_state_event;
    otg_set[BUS_ACTIVITY_BIT]  = bus_activity_event;
    otg_set[SESSION_VALID_BIT] = session_valid_event;
    otg_set[B_SESSION_END_BIT] = b_session_end_event;
    otg_set[A_VBUS_VALID_BIT]  = a_vbus_valid_event;
  end

  always_comb begin
    usb_set                   = 8'h00;
    usb_set[STALL_BIT]        = stall_event;
    usb_set[ATTACH_BIT]       = attach_event;
    usb_set[RESUME_BIT]       = resume_event;
    usb_set[BUS_IDLE_BIT]     = bus_idle_event;
    usb_set[TOKEN_DONE_BIT]   = token_done_flag;
    usb_set[FRAME_START_BIT]  = frame_start_flag;
    usb_set[ERROR_BIT]        = error_event;
    usb_set[RESET_DETACH_BIT] = bus_reset_flag || peer_detach_flag;
  end

  assign otg_clear = wr_access && hit(paddr, OTG_STATUS_OFS);
  assign usb_clear = wr_access && hit(paddr, USB_STATUS_OFS);

  sticky_flag_bank #(
    .WIDTH     (8),
    .IMPL_MASK (OTG_IMPL_MASK)
  ) otg_bank (
    .pclk         (pclk),
    .presetn      (presetn),
    .set_pulse    (otg_set),
    .clear_strobe (otg_clear),
    .clear_data   (pwdata[7:0]),
    .enable       (otg_irq_en_reg),
    .flags        (otg_flags),
    .irq          (otg_irq)
  );

  sticky_flag_bank #(
    .WIDTH     (8),
    .IMPL_MASK (USB_IMPL_MASK)
  ) usb_bank (
    .pclk         (pclk),
    .presetn      (presetn),
    .set_pulse    (usb_set),
    .clear_strobe (usb_clear),
    .clear_data   (pwdata[7:0]),
    .enable       (usb_irq_en_reg),
    .flags        (usb_flags),
    .irq          (usb_irq)
  );

  // Error class reaches the request only through its enable
  assign combined_usb_irq = otg_irq || usb_irq;
  assign host_mode        = host_mode_reg;

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (setup_phase && !pwrite) begin
      if (hit(paddr, OTG_STATUS_OFS)) begin
        prdata_reg <= word8(otg_flags);
      end else if (hit(paddr, OTG_IRQ_EN_OFS)) begin
        prdata_reg <= word8(otg_irq_en_reg);
      end else if (hit(paddr, USB_STATUS_OFS)) begin
        prdata_reg <= word8(usb_flags);
      end else if (hit(paddr, USB_IRQ_EN_OFS)) begin
        prdata_reg <= word8(usb_irq_en_reg);
      end else if (hit(paddr, FRAME_HIGH_OFS)) begin
        prdata_reg <= {29'h00000000, frame_upper_reg};
      end else if (hit(paddr, HOST_TOKEN_OFS)) begin
        prdata_reg <= word8(host_token_reg);
      end else if (hit(paddr, CONTROL_OFS)) begin
        prdata_reg <= {30'h00000000,
                       token_state_reg == TOKEN_BUSY,
                       host_mode_reg};
      end else begin
        prdata_reg <= 32'h00000000;
      end
    end
  end

  assign prdata = prdata_reg;

endmodule // usb_irq_token_regs

`default_nettype wire

// file: tb/usb_irq_token_props.sv
`timescale 1ns/1ps
`default_nettype none
module usb_irq_token_props
  import usb_irq_token_pkg::*;
#(parameter int ADDR_WIDTH = 8) (
  // Clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // APB
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // Token
  input wire logic                  token_start,
  input wire logic [3:0]            token_pid,
  input wire logic [3:0]            token_endpoint,
  input wire logic                  host_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic       acc = psel && penable;
  wire logic       rd  = acc && !pwrite;
  wire logic       tw  = acc && pwrite && paddr == HOST_TOKEN_OFS;
  wire logic [3:0] wp  = pwdata[7:4];
  wire logic [3:0] we  = pwdata[3:0];

  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_start_pulse: assert property (token_start |=> !token_start)
    else $error("token start longer than one cycle");
  chk_start_cause: assert property (
    token_start |-> $past(tw) && host_mode)
    else $error("token start without host token write");
  chk_token_fields: assert property (
    token_start |-> token_pid == $past(wp) && token_endpoint == $past(we))
    else $error("token fields differ from written value");
  chk_pid_hold: assert property (!$stable(token_pid) |-> $past(tw))
    else $error("token type changed without write");
  chk_err_access: assert property (pslverr |-> acc)
    else $error("slave error outside access phase");
  chk_otg_unimpl: assert property (
    rd && paddr == OTG_IRQ_EN_OFS |-> prdata[31:8] == 0 && !prdata[1])
    else $error("otg enable unimplemented bits not zero");
  chk_usb_unimpl: assert property (
    rd && paddr == USB_IRQ_EN_OFS |-> prdata[31:8] == 0)
    else $error("usb enable unimplemented bits not zero");
  chk_frame_upper: assert property (
    rd && paddr == FRAME_HIGH_OFS |-> prdata[31:3] == 0)
    else $error("frame high upper bits not zero");
endmodule // usb_irq_token_props

bind usb_irq_token_regs usb_irq_token_props #(.ADDR_WIDTH(ADDR_WIDTH)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .token_start(token_start),
  .token_pid(token_pid), .token_endpoint(token_endpoint),
  .host_mode(host_mode));
`default_nettype wire

// file: tb/usb_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far side: completes each started transaction after lat cycles
module usb_peer_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Transaction link
  input  wire logic       token_start,
  input  wire logic [7:0] lat,
  output logic            transaction_done
);
  logic [7:0] cnt_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_reg <= 8'h00;
    else if (token_start) cnt_reg <= lat;
    else if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
  end
  assign transaction_done = cnt_reg == 8'h01;
endmodule // usb_peer_model
`default_nettype wire

// file: tb/usb_otg_interrupt_token_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module usb_otg_interrupt_token_regs_bench;
  import usb_irq_token_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00, oev = 8'h00, uev = 8'h00, lat = 8'h06;
  logic [31:0] pwdata = 32'h0, r;
  logic [10:0] fnum = 11'h5A3;
  logic        det = 0, e;
  logic [3:0]  spid, sep;
  logic [3:0]  pids [3] = '{PID_OUT, PID_IN, PID_SETUP};
  wire logic [31:0] prdata;
  wire logic [3:0]  tpid, tep;
  wire logic        pready, pslverr, tstart, done, hmode, irq;
  int failures = 0, n_checks = 0, cyc = 0, starts = 0;

  always #2 pclk = ~pclk;

  usb_irq_token_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .id_change_event(oev[7]), .one_ms_timer_event(oev[6]),
    .line_state_event(oev[5]), .bus_activity_event(oev[4]),
    .session_valid_event(oev[3]), .b_session_end_event(oev[2]),
    .a_vbus_valid_event(oev[0]), .stall_event(uev[7]),
    .attach_event(uev[6]), .resume_event(uev[5]), .bus_idle_event(uev[4]),
    .error_event(uev[1]), .bus_reset_event(uev[0]),
    .peer_detach_event(det), .sof_received(uev[2]), .frame_number(fnum),
    .token_start(tstart), .token_pid(tpid), .token_endpoint(tep),
    .transaction_done(done), .host_mode(hmode), .combined_usb_irq(irq));

  usb_peer_model peer (.pclk(pclk), .presetn(presetn),
    .token_start(tstart), .lat(lat), .transaction_done(done));

  always @(posedge pclk) begin
    if (tstart === 1'b1) begin
      starts++;
      spid = tpid;
      sep = tep;
    end
  end

  task automatic conclude;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      failures++;
      conclude;
    end
  end

  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; result left in r and e
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] exp);
    xfer(0, a, 32'h0);
    chk(r, exp);
  endtask

  task automatic pulse(logic o, int b);
    @(posedge pclk);
    if (o) oev[b] <= 1; else uev[b] <= 1;
    @(posedge pclk);
    oev <= 8'h00; uev <= 8'h00;
  endtask

  // Flag set, gated by its enable, survives enable clear, cleared by W1C
  task automatic irq_case(logic o, int b);
    logic [7:0] so;
    logic [31:0] m;
    so = o ? OTG_STATUS_OFS : USB_STATUS_OFS;
    m = 32'h1 << b;
    pulse(o, b);
    rd(so, m);
    chk(irq, 0);
    xfer(1, so + 8'h04, m);
    rd(so + 8'h04, m);
    chk(irq, 1);
    xfer(1, so + 8'h04, 32'h0);
    rd(so, m);
    chk(irq, 0);
    xfer(1, so, m);
    rd(so, 32'h0);
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    for (int a = 0; a <= 24; a += 4) rd(8'(a), 32'h0);
    xfer(1, OTG_IRQ_EN_OFS, 32'hFFFFFFFF);
    rd(OTG_IRQ_EN_OFS, 32'h000000FD);
    xfer(1, USB_IRQ_EN_OFS, 32'hFFFFFFFF);
    rd(USB_IRQ_EN_OFS, 32'h000000FF);
    xfer(1, OTG_IRQ_EN_OFS, 32'h0);
    xfer(1, USB_IRQ_EN_OFS, 32'h0);
    // Unmapped word answers with an error and zero data
    xfer(0, 8'h1C, 32'h0);
    chk(e, 1);
    chk(r, 32'h0);
    xfer(1, FRAME_HIGH_OFS, 32'hFFFFFFFF);
    rd(FRAME_HIGH_OFS, 32'h0);
    for (int b = 0; b < 8; b++) begin
      if (b != 1) irq_case(1, b);
    end
    for (int b = 0; b < 8; b++) begin
      if (b != 3) irq_case(0, b);
    end
    rd(FRAME_HIGH_OFS, 32'h5);
    // Second frame start reloads the upper bits
    fnum <= 11'h2A3;
    pulse(0, 2);
    rd(FRAME_HIGH_OFS, 32'h2);
    xfer(1, USB_STATUS_OFS, 32'h4);
    xfer(1, CONTROL_OFS, 32'h1);
    rd(CONTROL_OFS, 32'h1);
    chk(hmode, 1);
    pulse(0, 0);
    rd(USB_STATUS_OFS, 32'h0);
    @(posedge pclk) det <= 1;
    @(posedge pclk) det <= 0;
    rd(USB_STATUS_OFS, 32'h1);
    xfer(1, USB_STATUS_OFS, 32'h1);
    xfer(1, USB_IRQ_EN_OFS, 32'h8);
    for (int i = 0; i < 3; i++) begin
      lat <= (i == 1) ? 8'd40 : 8'd6;
      xfer(1, HOST_TOKEN_OFS, {24'h0, pids[i], 4'(i + 5)});
      // Write while busy must be ignored
      xfer(1, HOST_TOKEN_OFS, {24'h0, PID_SETUP, 4'h2});
      for (int k = 0; k < 100 && irq !== 1'b1; k++) @(posedge pclk);
      chk(irq, 1);
      chk(starts, i + 1);
      chk({spid, sep}, {pids[i], 4'(i + 5)});
      rd(HOST_TOKEN_OFS, {24'h0, pids[i], 4'(i + 5)});
      xfer(1, USB_STATUS_OFS, 32'h8);
      rd(USB_STATUS_OFS, 32'h0);
    end
    xfer(1, CONTROL_OFS, 32'h0);
    xfer(1, HOST_TOKEN_OFS, 32'h00000093);
    repeat (20) @(posedge pclk);
    rd(HOST_TOKEN_OFS, 32'h00000093);
    chk(starts, 3);
    conclude;
  end
endmodule // usb_otg_interrupt_token_regs_bench
`default_nettype wire
